// [src/dual_timer_event_counter.sv]
// Purpose: two 16-bit timer/event counters on the special function bus
// Assumes: pins and bus synchronous to clock; one phase per enabled clock
// Notes:   hardware updates in phases one to four, bus read in five,
//          bus write in six, so a write lands after any hardware load
`timescale 1ns/10ps
`default_nettype none

`include "dual_timer_defs.svh"

// Functional notes
// - two 16-bit units, timer or event counter
// - mode 0 is a 13-bit counter
// - mode 1 cascades both bytes to 16 bits
// - mode 2 is 8-bit with high-byte reload
// - mode 3 splits only unit a
// - timer counts once per machine cycle
// - counter counts falling edges of its pin
// - pins sampled in phase five each cycle
// - new count visible in the next cycle
// - events limited to one per two cycles
// - unit b overflow pulse exported for baud
// - bus reads in phase five, writes six
// - flag a loaded phase two, b four
// - event flags set phase one, cleared two
// - bytes updated in phases one to four
// - phase six write beats hardware load
// - external irq edge or level triggered
// - two-bit mode, mode 3 freezes unit b
// - gate bit needs irq pin high too
// - overflow sets the unit overflow flag
// - select bit picks counter or timer
module dual_timer_event_counter
  import dual_timer_pkg::*;
(
  // clock and control
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  // special function bus
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrRead,
  input  wire logic       sfrWrite,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // external pins
  input  wire logic       countPinA,
  input  wire logic       countPinB,
  input  wire logic       extIrqPinA,
  input  wire logic       extIrqPinB,
  // interrupt vector taken
  input  wire logic       extAckA,
  input  wire logic       extAckB,
  // status to interrupt logic and uart
  output logic            unitAOverflowFlag,
  output logic            unitBOverflowFlag,
  output logic            extEventFlagA,
  output logic            extEventFlagB,
  output logic            unitBOverflowPulse
);

  // register file
  ctrl_s     ctrl;
  mode_cfg_s modeCfg;
  logic [7:0] unitACountLow;
  logic [7:0] unitACountHigh;
  logic [7:0] unitBCountLow;
  logic [7:0] unitBCountHigh;

  // machine cycle phase
  phase_e phase;

  // pin samples: 0 count a, 1 count b, 2 irq a, 3 irq b
  logic [3:0] pinIn;
  logic [3:0] pinCur;
  logic [3:0] pinPrev;
  logic [3:0] pinFall;

  // carries handed from low-byte phase to high-byte phase; split overflow from phase two to four
  logic aCarry;
  logic bCarry;
  logic splitOvf;

  // combinational terms
  logic       wrEn;
  logic       enableA;
  logic       enableB;
  logic       tickA;
  logic       tickB;
  logic       ovfASet;
  logic       ovfBOwn;
  logic       ovfBSet;
  logic [8:0] stepA;
  logic [8:0] stepB;
  logic [7:0] readMux;

  // low byte step by mode: {carry, next low}
  function automatic logic [8:0] step_low(input mode_e m, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [8:0] r;
    r = {1'b0, lo};
    unique case (m)
      MODE_13BIT: begin
        r = {lo[4:0] == `DT_PRESCALE_TOP, lo[7:5], lo[4:0] + `DT_PRESCALE_ONE};
      end
      MODE_16BIT: begin
        r = {lo == `DT_BYTE_TOP, lo + `DT_BYTE_ONE};
      end
      MODE_RELOAD8: begin
        r = (lo == `DT_BYTE_TOP) ? {1'b1, hi} : {1'b0, lo + `DT_BYTE_ONE};
      end
      MODE_SPLIT: begin
        r = {lo == `DT_BYTE_TOP, lo + `DT_BYTE_ONE};
      end
    endcase
    return r;
  endfunction

  // machine cycle sequencer
  phase_sequencer u_phase (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .phase (phase)
  );

  // pins gathered for the per-pin sampler
  assign pinIn = {extIrqPinB, extIrqPinA, countPinB, countPinA};

  // sample each pin once per machine cycle in phase five
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge clock) begin
        if (rst) begin
          pinCur[gi]  <= 1'b1;
          pinPrev[gi] <= 1'b1;
        end else if (ce && phase == PH_FIVE) begin
          pinPrev[gi] <= pinCur[gi];
          pinCur[gi]  <= pinIn[gi];
        end
      end
      // high in one sample, low in the next: one event per two cycles
      assign pinFall[gi] = pinPrev[gi] & ~pinCur[gi];
    end
  endgenerate

  // bus write strobe, phase six only
  assign wrEn = ce & sfrWrite & (phase == PH_SIX);

  // run enables with optional gating by the irq pin level
  assign enableA = ctrl.runA & (~modeCfg.a.pinGate | pinCur[2]);
  assign enableB = ctrl.runB & (~modeCfg.b.pinGate | pinCur[3]);

  // count ticks: machine cycle or detected falling edge
  assign tickA = enableA & (modeCfg.a.countSelect ? pinFall[0] : 1'b1);
  assign tickB = enableB & (modeCfg.b.mode != MODE_SPLIT)
               & (modeCfg.b.countSelect ? pinFall[1] : 1'b1);

  // low byte next values
  assign stepA = step_low(modeCfg.a.mode, unitACountLow, unitACountHigh);
  assign stepB = step_low(modeCfg.b.mode, unitBCountLow, unitBCountHigh);

  // unit a overflow: high byte wrap, or low byte wrap in modes 2 and 3
  always_comb begin
    ovfASet = 1'b0;
    if (phase == PH_TWO && aCarry) begin
      unique case (modeCfg.a.mode)
        MODE_13BIT:   ovfASet = (unitACountHigh == `DT_BYTE_TOP);
        MODE_16BIT:   ovfASet = (unitACountHigh == `DT_BYTE_TOP);
        MODE_RELOAD8: ovfASet = 1'b1;
        MODE_SPLIT:   ovfASet = 1'b1;
      endcase
    end
  end

  // unit b overflow from its own count
  always_comb begin
    ovfBOwn = 1'b0;
    if (phase == PH_FOUR && bCarry) begin
      unique case (modeCfg.b.mode)
        MODE_13BIT:   ovfBOwn = (unitBCountHigh == `DT_BYTE_TOP);
        MODE_16BIT:   ovfBOwn = (unitBCountHigh == `DT_BYTE_TOP);
        MODE_RELOAD8: ovfBOwn = 1'b1;
        MODE_SPLIT:   ovfBOwn = 1'b0;
      endcase
    end
  end

  // unit b flag also takes the split high byte of unit a
  assign ovfBSet = ovfBOwn | (phase == PH_FOUR && splitOvf);

  // unit a low byte, hardware in phase one
  always_ff @(posedge clock) begin
    if (rst) begin
      unitACountLow <= `DT_COUNT_RESET;
      aCarry        <= 1'b0;
    end else if (ce) begin
      if (phase == PH_ONE) begin
        aCarry <= tickA & stepA[8];
        if (tickA) begin
          unitACountLow <= stepA[7:0];
        end
      end
      if (wrEn && sfrAddr == `DT_ADDR_A_LOW) begin
        unitACountLow <= sfrWdata;
      end
    end
  end

  // unit a high byte, hardware in phase two
  always_ff @(posedge clock) begin
    if (rst) begin
      unitACountHigh <= `DT_COUNT_RESET;
      splitOvf       <= 1'b0;
    end else if (ce) begin
      if (phase == PH_TWO) begin
        splitOvf <= 1'b0;
        unique case (modeCfg.a.mode)
          MODE_13BIT, MODE_16BIT: begin
            if (aCarry) begin
              unitACountHigh <= unitACountHigh + `DT_BYTE_ONE;
            end
          end
          MODE_RELOAD8: begin
            unitACountHigh <= unitACountHigh;
          end
          MODE_SPLIT: begin
            // second 8-bit timer runs on unit b run control
            if (ctrl.runB) begin
              unitACountHigh <= unitACountHigh + `DT_BYTE_ONE;
              splitOvf       <= (unitACountHigh == `DT_BYTE_TOP);
            end
          end
        endcase
      end
      if (wrEn && sfrAddr == `DT_ADDR_A_HIGH) begin
        unitACountHigh <= sfrWdata;
      end
    end
  end

  // unit b low byte, hardware in phase three
  always_ff @(posedge clock) begin
    if (rst) begin
      unitBCountLow <= `DT_COUNT_RESET;
      bCarry        <= 1'b0;
    end else if (ce) begin
      if (phase == PH_THREE) begin
        bCarry <= tickB & stepB[8];
        if (tickB) begin
          unitBCountLow <= stepB[7:0];
        end
      end
      if (wrEn && sfrAddr == `DT_ADDR_B_LOW) begin
        unitBCountLow <= sfrWdata;
      end
    end
  end

  // unit b high byte, hardware in phase four
  always_ff @(posedge clock) begin
    if (rst) begin
      unitBCountHigh <= `DT_COUNT_RESET;
    end else if (ce) begin
      if (phase == PH_FOUR && bCarry &&
          (modeCfg.b.mode == MODE_13BIT || modeCfg.b.mode == MODE_16BIT)) begin
        unitBCountHigh <= unitBCountHigh + `DT_BYTE_ONE;
      end
      if (wrEn && sfrAddr == `DT_ADDR_B_HIGH) begin
        unitBCountHigh <= sfrWdata;
      end
    end
  end

  // control flags: hardware phases one, two, four, then bus write
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= ctrl_s'(`DT_CTRL_RESET);
    end else if (ce) begin
      // event flags set in phase one
      if (phase == PH_ONE) begin
        if (ctrl.extEdgeA ? pinFall[2] : ~pinCur[2]) begin
          ctrl.extFlagA <= 1'b1;
        end
        if (ctrl.extEdgeB ? pinFall[3] : ~pinCur[3]) begin
          ctrl.extFlagB <= 1'b1;
        end
      end
      // event flags cleared in phase two, overflow a loaded
      if (phase == PH_TWO) begin
        if (extAckA || (!ctrl.extEdgeA && pinCur[2])) begin
          ctrl.extFlagA <= 1'b0;
        end
        if (extAckB || (!ctrl.extEdgeB && pinCur[3])) begin
          ctrl.extFlagB <= 1'b0;
        end
        if (ovfASet) begin
          ctrl.ovfA <= 1'b1;
        end
      end
      // overflow b loaded in phase four
      if (ovfBSet) begin
        ctrl.ovfB <= 1'b1;
      end
      if (wrEn && sfrAddr == `DT_ADDR_CTRL) begin
        ctrl <= ctrl_s'(sfrWdata);
      end
    end
  end

  // mode register, firmware only
  always_ff @(posedge clock) begin
    if (rst) begin
      modeCfg <= mode_cfg_s'(`DT_MODE_RESET);
    end else if (ce && wrEn && sfrAddr == `DT_ADDR_MODE) begin
      modeCfg <= mode_cfg_s'(sfrWdata);
    end
  end

  // one-clock pulse on each unit b overflow, for the uart baud
  always_ff @(posedge clock) begin
    if (rst) begin
      unitBOverflowPulse <= 1'b0;
    end else if (ce) begin
      unitBOverflowPulse <= ovfBOwn;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    unique case (sfrAddr)
      `DT_ADDR_CTRL:   readMux = ctrl;
      `DT_ADDR_MODE:   readMux = modeCfg;
      `DT_ADDR_A_LOW:  readMux = unitACountLow;
      `DT_ADDR_B_LOW:  readMux = unitBCountLow;
      `DT_ADDR_A_HIGH: readMux = unitACountHigh;
      `DT_ADDR_B_HIGH: readMux = unitBCountHigh;
      default:         readMux = `DT_RDATA_RESET;
    endcase
  end

  // read data captured in phase five, held until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      sfrRdata <= `DT_RDATA_RESET;
    end else if (ce && sfrRead && phase == PH_FIVE) begin
      sfrRdata <= readMux;
    end
  end

  // status flags straight from the control register
  assign unitAOverflowFlag = ctrl.ovfA;
  assign unitBOverflowFlag = ctrl.ovfB;
  assign extEventFlagA     = ctrl.extFlagA;
  assign extEventFlagB     = ctrl.extFlagB;

endmodule

`default_nettype wire

// [src/dual_timer_defs.svh]
// Purpose: constants of the dual timer/event counter
// Assumes: included by bare name from the design file
// Notes:   special function register addresses and reset values
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

// special function register addresses
`define DT_ADDR_CTRL     8'h88
`define DT_ADDR_MODE     8'h89
`define DT_ADDR_A_LOW    8'h8A
`define DT_ADDR_B_LOW    8'h8B
`define DT_ADDR_A_HIGH   8'h8C
`define DT_ADDR_B_HIGH   8'h8D

// reset values
`define DT_CTRL_RESET    8'h00
`define DT_MODE_RESET    8'h00
`define DT_COUNT_RESET   8'h00
`define DT_RDATA_RESET   8'h00

// count limits
`define DT_BYTE_TOP      8'hFF
`define DT_PRESCALE_TOP  5'h1F
`define DT_PRESCALE_ONE  5'h01
`define DT_BYTE_ONE      8'h01

`endif

// [src/dual_timer_pkg.sv]
// Purpose: types of the dual timer/event counter
// Assumes: layouts follow the control and mode registers, bit 7 first
// Notes:   constants live in dual_timer_defs.svh
package dual_timer_pkg;

  // machine cycle phases, one per CPU clock
  typedef enum logic [2:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR,
    PH_FIVE,
    PH_SIX
  } phase_e;

  // unit mode field, declaration order gives codes 00..11
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } mode_e;

  // per-unit field of the mode register
  typedef struct packed {
    logic  pinGate;
    logic  countSelect;
    mode_e mode;
  } unit_cfg_s;

  // timer_mode_config layout
  typedef struct packed {
    unit_cfg_s b;
    unit_cfg_s a;
  } mode_cfg_s;

  // timer_control_flags layout
  typedef struct packed {
    logic ovfB;
    logic runB;
    logic ovfA;
    logic runA;
    logic extFlagB;
    logic extEdgeB;
    logic extFlagA;
    logic extEdgeA;
  } ctrl_s;

endpackage

// [src/phase_sequencer.sv]
// Purpose: six-phase machine cycle sequencer
// Assumes: one phase per enabled CPU clock
// Notes:   reset starts the cycle in phase one
`timescale 1ns/10ps
`default_nettype none

module phase_sequencer
  import dual_timer_pkg::*;
(
  // clock and control
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  ce,
  // current phase
  output var phase_e phase
);

  // step through the six phases and wrap
  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= PH_ONE;
    end else if (ce) begin
      unique case (phase)
        PH_ONE:   phase <= PH_TWO;
        PH_TWO:   phase <= PH_THREE;
        PH_THREE: phase <= PH_FOUR;
        PH_FOUR:  phase <= PH_FIVE;
        PH_FIVE:  phase <= PH_SIX;
        PH_SIX:   phase <= PH_ONE;
        default:  phase <= PH_ONE;
      endcase
    end
  end

endmodule

`default_nettype wire

// [test/dual_timer_event_counter_properties.sv]
// Purpose: port timing checks of the dual timer
// Assumes: phase rebuilt from reset and ce
// Notes:   ph holds the phase index of the next edge
`timescale 1ns/10ps
`default_nettype none

module dual_timer_event_counter_properties (
  // clock and control
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       ce,
  // register bus
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrRead,
  input wire logic       sfrWrite,
  input wire logic [7:0] sfrRdata,
  // status
  input wire logic       unitAOverflowFlag,
  input wire logic       unitBOverflowFlag,
  input wire logic       extEventFlagA,
  input wire logic       unitBOverflowPulse
);
  logic [2:0] ph;
  logic       wrote;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // phase count and phase-six control write
  always_ff @(posedge clock) begin
    if (rst) begin
      ph    <= 3'h0;
      wrote <= 1'b0;
    end else if (ce) begin
      ph    <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      wrote <= ph == 3'h5 && sfrWrite && sfrAddr == 8'h88;
    end
  end
  // read of an unmapped address in phase five
  sequence unmapped_read;
    ph == 3'h4 && ce && sfrRead && !(sfrAddr inside {[8'h88:8'h8D]});
  endsequence
  // baud pulse start
  sequence pulse_start;
    $rose(unitBOverflowPulse);
  endsequence

  a_flag_a_phase: assert property ($rose(unitAOverflowFlag) |-> ph == 3'h2 || wrote)
    else $error("unit a flag rose off phase two");
  a_flag_b_phase: assert property ($rose(unitBOverflowFlag) |-> ph == 3'h4 || wrote)
    else $error("unit b flag rose off phase four");
  a_event_set_phase: assert property ($rose(extEventFlagA) |-> ph == 3'h1 || wrote)
    else $error("event flag set off phase one");
  a_event_clear_phase: assert property ($fell(extEventFlagA) |-> ph == 3'h2 || wrote || $past(rst))
    else $error("event flag cleared off phase two");
  a_pulse_one_clock: assert property (unitBOverflowPulse |=> !unitBOverflowPulse)
    else $error("baud pulse longer than a clock");
  a_pulse_with_flag: assert property (pulse_start |-> unitBOverflowFlag && ph inside {3'h4, 3'h5})
    else $error("baud pulse without unit b flag");
  a_rdata_on_read: assert property (!$stable(sfrRdata) |-> (ph == 3'h5 && $past(sfrRead)) || $past(rst))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (unmapped_read |=> ##1 sfrRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind dual_timer_event_counter dual_timer_event_counter_properties i_props (.clock(clock), .rst(rst), .ce(ce),
  .sfrAddr(sfrAddr), .sfrRead(sfrRead), .sfrWrite(sfrWrite), .sfrRdata(sfrRdata),
  .unitAOverflowFlag(unitAOverflowFlag), .unitBOverflowFlag(unitBOverflowFlag),
  .extEventFlagA(extEventFlagA), .unitBOverflowPulse(unitBOverflowPulse));
`default_nettype wire

// [test/count_pin_source.sv]
// Purpose: external event source on a count pin
// Assumes: one fall per fire request
// Notes:   idles high, low held whole machine cycles
`timescale 1ns/10ps
`default_nettype none

module count_pin_source (
  // clock and control
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       fire,
  input  wire logic [3:0] holdCycles,
  // count pin
  output logic            pin
);
  int left;
  // falls on fire, rises after the hold span
  always_ff @(posedge clock) begin
    if (rst) begin
      pin  <= 1'b1;
      left <= 0;
    end else if (fire) begin
      pin  <= 1'b0;
      left <= 6 * holdCycles;
    end else if (left > 1) begin
      left <= left - 1;
    end else begin
      pin  <= 1'b1;
      left <= 0;
    end
  end
endmodule
`default_nettype wire

// [test/dual_timer_event_counter_test.sv]
// Purpose: self-checking bench of the dual timer/event counter
// Assumes: phases advance only on clocks with ce high
// Notes:   ph is the phase index of the next rising edge
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end

module dual_timer_event_counter_test;
  logic       clock, rst, ce, sfrRead, sfrWrite;
  logic [1:0] irq, ack;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  logic       countPinA, countPinB, flagA, flagB, evA, evB, pulse;
  logic [1:0] fire;
  logic [3:0] hold;
  int         n_fail, compares, ph, pulses, seed;

  dual_timer_event_counter i_dut (.clock(clock), .rst(rst), .ce(ce), .sfrAddr(sfrAddr), .sfrRead(sfrRead),
    .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .countPinA(countPinA), .countPinB(countPinB),
    .extIrqPinA(irq[0]), .extIrqPinB(irq[1]), .extAckA(ack[0]), .extAckB(ack[1]),
    .unitAOverflowFlag(flagA), .unitBOverflowFlag(flagB), .extEventFlagA(evA), .extEventFlagB(evB),
    .unitBOverflowPulse(pulse));
  count_pin_source i_srcA (.clock(clock), .rst(rst), .fire(fire[0]), .holdCycles(hold), .pin(countPinA));
  count_pin_source i_srcB (.clock(clock), .rst(rst), .fire(fire[1]), .holdCycles(hold), .pin(countPinB));

  // clock at 125 MHz
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // phase tracking and baud pulse count
  always @(posedge clock) ph <= rst ? 0 : ce ? (ph + 1) % 6 : ph;
  always @(posedge clock) if (pulse === 1'b1) pulses <= pulses + 1;

  // write a register at a phase-six edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    while (ph != 5) @(negedge clock);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clock);
    sfrWrite = 1'b0;
  endtask

  // read a register at a phase-five edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    while (ph != 4) @(negedge clock);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clock);
    sfrRead = 1'b0;
    @(negedge clock);
    d = sfrRdata;
  endtask

  // one count step of the reference model, o counts overflows
  function automatic void step(input int m, inout int h, inout int l, inout int o);
    if (m == 0) l = (l & 224) | ((l + 1) & 31);
    else l = l + 1;
    if (m == 0 ? (l & 31) != 0 : l < 256) return;
    l = (m == 2) ? h : l & 255;
    if (m < 2) h = (h + 1) & 255;
    if (m > 1 || h == 0) o++;
  endfunction

  // configure, run k cycles or k events, stop and compare
  // m: bits 1:0 mode, 2 count pin, 3 gate, 4 unit a split with unit b run
  task automatic run(input int u, input int m, input int k);
    int h, l, o, n, i;
    logic [7:0] d;
    l = 8'hF9 + $unsigned($random(seed)) % 7;
    h = (m[1:0] == 2) ? $unsigned($random(seed)) % 256 : 255;
    o = 0;
    n = pulses;
    wr(8'h89, 8'((m & 15) << (4 * u)) | (m[4] ? 8'h30 : 8'h00));
    wr(8'h8A + 8'(u), 8'(l));
    wr(8'h8C + 8'(u), 8'(h));
    wr(8'h88, u ? 8'h40 : (m[4] ? 8'h50 : 8'h10));
    if (m[2]) begin
      for (i = 0; i < k; i++) begin
        fire[u] = 1'b1;
        @(negedge clock);
        fire[u] = 1'b0;
        repeat (12 * hold) @(negedge clock);
      end
      repeat (12) @(negedge clock);
    end else begin
      repeat (6 * k - 6) @(negedge clock);
      // ce low must freeze phase and counts
      ce = 1'b0;
      repeat (7) @(negedge clock);
      ce = 1'b1;
    end
    for (i = 0; i < k; i++) if (!(m[3] && !irq[u]) && !(u == 1 && m[1:0] == 3)) step(m[1:0], h, l, o);
    while (ph != 5) @(negedge clock);
    `CHK("overflow flag", o != 0, u ? flagB : flagA)
    // split high byte: machine cycles on unit b run, overflow to unit b flag
    if (m[4]) `CHK("split overflow", h + k > 255, flagB)
    if (m[4]) h = (h + k) & 255;
    wr(8'h88, 8'h00);
    rd(8'h8A + 8'(u), d);
    `CHK("count low", l, d)
    rd(8'h8C + 8'(u), d);
    `CHK("count high", h, d)
    `CHK("baud pulses", u ? o : 0, pulses - n)
  endtask

  // external event flag set and clear
  task automatic evt(input int u, input logic edgeMode);
    wr(8'h88, 8'(edgeMode) << (2 * u));
    irq[u] = 1'b0;
    repeat (12) @(negedge clock);
    `CHK("event flag set", 1'b1, u ? evB : evA)
    irq[u] = 1'b1;
    repeat (12) @(negedge clock);
    `CHK("event flag held", edgeMode, u ? evB : evA)
    ack[u] = 1'b1;
    repeat (12) @(negedge clock);
    ack[u] = 1'b0;
    `CHK("event flag clear", 1'b0, u ? evB : evA)
  endtask

  // print the counts and the verdict, then end the run
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog on a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    results;
  end

  // main sequence
  initial begin
    int a, m;
    logic [7:0] d, v;
    seed = 32'hB71F;
    {rst, ce, sfrRead, sfrWrite, irq, ack} = 8'hCC;
    {sfrAddr, sfrWdata, fire, hold} = '0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    for (a = 8'h87; a < 8'h8F; a++) begin
      rd(8'(a), d);
      `CHK("reset value", 8'h00, d)
    end
    for (a = 8'h89; a < 8'h8E; a++) begin
      v = 8'($random(seed));
      wr(8'(a), v);
      rd(8'(a), d);
      `CHK("readback", v, d)
    end
    for (m = 0; m < 4; m++) begin
      run(0, m, 7 + $unsigned($random(seed)) % 2);
      run(1, m, 7 + $unsigned($random(seed)) % 2);
    end
    hold = 4'(1 + $unsigned($random(seed)) % 3);
    run(0, 5, 3);
    hold = 4'h1;
    run(1, 5, 3);
    irq[0] = 1'b0;
    run(0, 9, 4);
    irq[0] = 1'b1;
    run(0, 9, 4);
    irq[1] = 1'b0;
    run(1, 9, 4);
    irq[1] = 1'b1;
    run(1, 9, 4);
    run(0, 19, 5);
    for (a = 0; a < 2; a++) begin
      evt(a, 1'b1);
      evt(a, 1'b0);
    end
    results;
  end
endmodule
`default_nettype wire
